// [dcfd_pkg.sv]
package dcfd_pkg;

  // Channel count and code widths.
  localparam int CH_N   = 2;
  localparam int CODE_W = 12;
  localparam int ADDR_W = 8;

  // Register word indices; byte address is four times the index.
  localparam logic [3:0] IDX_VOUT     = 4'h0;
  localparam logic [3:0] IDX_MODE     = 4'h2;
  localparam logic [3:0] IDX_MHIGH    = 4'h4;
  localparam logic [3:0] IDX_MLOW     = 4'h6;
  localparam logic [3:0] IDX_DATA     = 4'h8;
  localparam logic [3:0] IDX_CCONFIG  = 4'ha;
  localparam logic [3:0] IDX_CHTRIG   = 4'hb;
  localparam logic [3:0] IDX_CTRIG    = 4'hc;
  localparam logic [3:0] IDX_STATUS   = 4'hd;
  localparam logic [3:0] IDX_STG_ADDR = 4'he;
  localparam logic [3:0] IDX_STG_DATA = 4'hf;

  // Field positions.
  localparam int CC_WIN_LATCH   = 0;
  localparam int CC_ROW_SEL     = 1;
  localparam int CC_GPIO_WIN    = 2;
  localparam int CT_FAULT_DUMP  = 0;
  localparam int CT_READ_ONE    = 1;
  localparam int ST_WIN_LSB     = 0;
  localparam int ST_CMP_LSB     = 2;
  localparam int ST_BUSY        = 4;
  localparam int DATA_CODE_LSB  = 4;
  localparam int DATA_HI_LSB    = 8;
  localparam int ROW_HI_LSB     = 24;
  localparam int ROW_LO_LSB     = 0;
  localparam int HALF_W         = 16;

  // Writable bits of each stored word; reset value of all is zero.
  localparam logic [31:0] WMASK [16] = '{
    32'h0000_001f, 32'h0000_001f, 32'h0000_0003, 32'h0000_0003,
    32'h0000_0fff, 32'h0000_0fff, 32'h0000_0fff, 32'h0000_0fff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_0007, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000};

  localparam logic [CODE_W-1:0] CODE_FULL   = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ZERO   = 12'h000;
  localparam logic [15:0]       STG_LO_ADDR = 16'h009d;
  localparam logic [15:0]       STG_HI_ADDR = 16'h009e;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // Nonvolatile write cycle time and its cycle count at 50 MHz.
  localparam int CLK_NS        = 20;
  localparam int NV_WRITE_NS   = 10000;
  localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 10;
  localparam logic [CNT_W-1:0] NV_WRITE_LAST = CNT_W'(NV_WRITE_CYC - 1);

  typedef enum logic [1:0] {
    CMP_NORMAL  = 2'h0,
    CMP_HYST    = 2'h1,
    CMP_WINDOW  = 2'h2,
    CMP_INVALID = 2'h3
  } cmp_mode_t;

  typedef enum logic {NV_IDLE, NV_DUMP} nv_state_t;

  // Per-channel output and input configuration word.
  typedef struct packed {
    logic fb_hiz_disable;
    logic cmp_invert_enable;
    logic cmp_open_drain_sel;
    logic cmp_pin_out_enable;
    logic cmp_enable;
  } vout_cfg_t;

endpackage

// [dac_comparator_fault_dump_ctrl.sv]
// What this block does
// - Comparator runs only when cmp_enable is set.
// - Pin driven only when output enable set.
// - Open-drain select picks open-drain, else push-pull.
// - Invert enable inverts the pin value.
// - Feedback input high-impedance unless disable bit set.
// - Mode 00 normal, 01 hysteresis, 10 window.
// - Hysteresis uses margin-high and margin-low thresholds.
// - Full or zero threshold makes hysteresis latching.
// - Flag-reset write releases latched output: high if margin-high is full, else low.
// - Latched reset acts only between the thresholds.
// - Window result shown in window status bits.
// - Window latch enable holds status until reset.
// - Window reset acts only inside the window.
// - Window status not on pin; readable, GPIO option.
// - Fault dump stores status and data upper bytes.
// - Row one holds status byte in top byte.
// - Row select picks row one or row two.
// - Read trigger copies row to staging, self-clears.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module dac_comparator_fault_dump_ctrl (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [dcfd_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [dcfd_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  output var  logic [31:0]                      s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic [1:0][dcfd_pkg::CODE_W-1:0] feedback_input,
  output var  logic [1:0]                       cmp_pin_out,
  output var  logic [1:0]                       cmp_pin_oe,
  output var  logic [1:0]                       fb_hiz_off,
  input  wire logic                             gpio_in,
  output var  logic                             gpio_out,
  output var  logic                             gpio_oe
);

  logic [31:0]                  cfg [16];
  logic                         aw_have;
  logic                         w_have;
  logic [dcfd_pkg::ADDR_W-1:0]  aw_addr;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic [31:0]                  w_mask;
  logic [31:0]                  w_bits;
  logic                         wr_fire;
  logic                         wr_bad;
  logic [3:0]                   wr_idx;
  logic [31:0]                  rd_word;
  logic                         rd_bad;
  logic [3:0]                   rd_idx;
  logic [dcfd_pkg::CODE_W-1:0]  fb_s1 [dcfd_pkg::CH_N];
  logic [dcfd_pkg::CODE_W-1:0]  fb_s2 [dcfd_pkg::CH_N];
  logic                         cmp_res [dcfd_pkg::CH_N];
  logic                         win_bit [dcfd_pkg::CH_N];
  logic [1:0]                   flag_rst;
  logic [7:0]                   status_byte;
  logic                         gp_s1;
  logic                         gp_s2;
  logic                         gp_s3;
  logic                         gp_fall;
  logic                         gpio_win_route;
  logic                         dump_req;
  logic                         read_one_req;
  dcfd_pkg::nv_state_t          nv_state;
  logic [dcfd_pkg::CNT_W-1:0]   nv_cnt;
  logic [31:0]                  nv_row [2];
  logic [15:0]                  stage_lo;
  logic [15:0]                  stage_hi;

  // Write address channel: accept one address, hold it until the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_have       <= 1'b0;
      aw_addr       <= '0;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_have
                       & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_have       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else begin
      s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_have
                      & ~s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
    end
  end

  // Decode of the held write; byte strobes build the lane mask.
  always_comb begin
    wr_fire = aw_have & w_have & ~s_axi_bvalid;
    wr_bad  = |aw_addr[dcfd_pkg::ADDR_W-1:6];
    wr_idx  = aw_addr[5:2];
    for (int b = 0; b < 4; b++) begin
      w_mask[8*b +: 8] = {8{w_strb[b]}};
    end
    w_bits  = w_data & w_mask;
  end

  // Write response; an address beyond the map answers with SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dcfd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? dcfd_pkg::RESP_SLVERR
                             : dcfd_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Stored configuration words; only writable bits ever change.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= '0;
      end
    end else if (wr_fire && !wr_bad) begin
      cfg[wr_idx] <= (cfg[wr_idx] & ~(w_mask & dcfd_pkg::WMASK[wr_idx]))
                     | (w_bits & dcfd_pkg::WMASK[wr_idx]);
    end
  end

  // Trigger bits act as one-cycle pulses and are never stored.
  always_comb begin
    flag_rst = 2'h0;
    dump_req = gp_fall & ~gpio_win_route;
    read_one_req = 1'b0;
    if (wr_fire && !wr_bad && wr_idx == dcfd_pkg::IDX_CHTRIG) begin
      flag_rst = w_bits[1:0];
    end
    if (wr_fire && !wr_bad && wr_idx == dcfd_pkg::IDX_CTRIG) begin
      dump_req = dump_req | w_bits[dcfd_pkg::CT_FAULT_DUMP];
      read_one_req = w_bits[dcfd_pkg::CT_READ_ONE];
    end
  end

  assign gpio_win_route = cfg[dcfd_pkg::IDX_CCONFIG][dcfd_pkg::CC_GPIO_WIN];

  // Read address channel: one read at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    end
  end

  // Read word selection for the requested index.
  always_comb begin
    rd_bad  = |s_axi_araddr[dcfd_pkg::ADDR_W-1:6];
    rd_idx  = s_axi_araddr[5:2];
    rd_word = cfg[rd_idx];
    unique case (rd_idx)
      dcfd_pkg::IDX_STATUS: begin
        rd_word = {24'h00_0000, status_byte};
      end
      dcfd_pkg::IDX_CTRIG: begin
        rd_word = 32'h0000_0000;
        rd_word[dcfd_pkg::CT_FAULT_DUMP] = (nv_state == dcfd_pkg::NV_DUMP);
      end
      dcfd_pkg::IDX_STG_DATA: begin
        rd_word = 32'h0000_0000;
        if (cfg[dcfd_pkg::IDX_STG_ADDR][15:0] == dcfd_pkg::STG_LO_ADDR) begin
          rd_word[15:0] = stage_lo;
        end else if (cfg[dcfd_pkg::IDX_STG_ADDR][15:0]
                     == dcfd_pkg::STG_HI_ADDR) begin
          rd_word[15:0] = stage_hi;
        end
      end
      default: begin
        rd_word = cfg[rd_idx];
      end
    endcase
  end

  // Read data channel holds its word until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dcfd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_bad ? 32'h0000_0000 : rd_word;
      s_axi_rresp  <= rd_bad ? dcfd_pkg::RESP_SLVERR
                             : dcfd_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // The general-purpose pin comes from outside; two flops, then an edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_s1 <= 1'b1;
      gp_s2 <= 1'b1;
      gp_s3 <= 1'b1;
    end else begin
      gp_s1 <= gpio_in;
      gp_s2 <= gp_s1;
      gp_s3 <= gp_s2;
    end
  end

  assign gp_fall = gp_s3 & ~gp_s2;

  // Per-channel comparator, window flag and pin driver.
  for (genvar ch = 0; ch < dcfd_pkg::CH_N; ch++) begin : g_ch
    dcfd_pkg::vout_cfg_t          vc;
    dcfd_pkg::cmp_mode_t          md;
    logic [dcfd_pkg::CODE_W-1:0]  mh;
    logic [dcfd_pkg::CODE_W-1:0]  ml;
    logic [dcfd_pkg::CODE_W-1:0]  thr;
    logic [dcfd_pkg::CODE_W-1:0]  fb;
    logic                         between;
    logic                         latching;
    logic                         pin_val;

    assign vc = dcfd_pkg::vout_cfg_t'(
                cfg[dcfd_pkg::IDX_VOUT + 4'(ch)][4:0]);
    assign md = dcfd_pkg::cmp_mode_t'(
                cfg[dcfd_pkg::IDX_MODE + 4'(ch)][1:0]);
    assign mh = cfg[dcfd_pkg::IDX_MHIGH + 4'(ch)][dcfd_pkg::CODE_W-1:0];
    assign ml = cfg[dcfd_pkg::IDX_MLOW + 4'(ch)][dcfd_pkg::CODE_W-1:0];
    assign thr = cfg[dcfd_pkg::IDX_DATA + 4'(ch)]
                    [dcfd_pkg::DATA_CODE_LSB +: dcfd_pkg::CODE_W];
    assign fb = fb_s2[ch];
    assign between = (fb >= ml) && (fb <= mh);
    assign latching = (mh == dcfd_pkg::CODE_FULL)
                      || (ml == dcfd_pkg::CODE_ZERO);
    assign pin_val = cmp_res[ch] ^ vc.cmp_invert_enable;

    // The input code comes from the converter; two flops before use.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fb_s1[ch] <= '0;
        fb_s2[ch] <= '0;
      end else begin
        fb_s1[ch] <= feedback_input[ch];
        fb_s2[ch] <= fb_s1[ch];
      end
    end

    // Comparator result for normal and hysteresis modes.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_res[ch] <= 1'b0;
      end else if (!vc.cmp_enable) begin
        cmp_res[ch] <= 1'b0;
      end else begin
        unique case (md)
          dcfd_pkg::CMP_NORMAL: begin
            cmp_res[ch] <= fb > thr;
          end
          dcfd_pkg::CMP_HYST: begin
            if (!latching) begin
              if (fb > mh) begin
                cmp_res[ch] <= 1'b1;
              end else if (fb < ml) begin
                cmp_res[ch] <= 1'b0;
              end
            end else if (flag_rst[ch] && between) begin
              cmp_res[ch] <= (mh == dcfd_pkg::CODE_FULL);
            end else if (mh == dcfd_pkg::CODE_FULL && fb < ml) begin
              cmp_res[ch] <= 1'b0;
            end else if (ml == dcfd_pkg::CODE_ZERO && fb > mh) begin
              cmp_res[ch] <= 1'b1;
            end
          end
          dcfd_pkg::CMP_WINDOW, dcfd_pkg::CMP_INVALID: begin
            cmp_res[ch] <= 1'b0;
          end
        endcase
      end
    end

    // Window flag: set outside the bounds; in window mode with the comparator on, cleared only from inside.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        win_bit[ch] <= 1'b0;
      end else if (!vc.cmp_enable || md != dcfd_pkg::CMP_WINDOW) begin
        win_bit[ch] <= 1'b0;
      end else if (!between) begin
        win_bit[ch] <= 1'b1;
      end else if (!cfg[dcfd_pkg::IDX_CCONFIG][dcfd_pkg::CC_WIN_LATCH]) begin
        win_bit[ch] <= 1'b0;
      end else if (flag_rst[ch]) begin
        win_bit[ch] <= 1'b0;
      end
    end

    // Pin driver: off, push-pull or open-drain (drives low only).
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_pin_out[ch] <= 1'b0;
        cmp_pin_oe[ch]  <= 1'b0;
        fb_hiz_off[ch]  <= 1'b0;
      end else begin
        fb_hiz_off[ch] <= vc.fb_hiz_disable;
        if (!(vc.cmp_enable && vc.cmp_pin_out_enable)) begin
          cmp_pin_out[ch] <= 1'b0;
          cmp_pin_oe[ch]  <= 1'b0;
        end else if (vc.cmp_open_drain_sel) begin
          cmp_pin_out[ch] <= 1'b0;
          cmp_pin_oe[ch]  <= ~pin_val;
        end else begin
          cmp_pin_out[ch] <= pin_val;
          cmp_pin_oe[ch]  <= 1'b1;
        end
      end
    end
  end

  // Status byte: window flags, comparator results and dump busy.
  always_comb begin
    status_byte = 8'h00;
    for (int c = 0; c < dcfd_pkg::CH_N; c++) begin
      status_byte[dcfd_pkg::ST_WIN_LSB + c] = win_bit[c];
      status_byte[dcfd_pkg::ST_CMP_LSB + c] = cmp_res[c];
    end
    status_byte[dcfd_pkg::ST_BUSY] = (nv_state == dcfd_pkg::NV_DUMP);
  end

  // Open-drain window alarm on the general-purpose pin when routed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_out <= 1'b0;
      gpio_oe  <= 1'b0;
    end else begin
      gpio_out <= 1'b0;
      gpio_oe  <= gpio_win_route & (win_bit[0] | win_bit[1]);
    end
  end

  // Dump sequencer: rows are written at the end of the write cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_state <= dcfd_pkg::NV_IDLE;
      nv_cnt   <= '0;
    end else begin
      unique case (nv_state)
        dcfd_pkg::NV_IDLE: begin
          nv_cnt <= '0;
          if (dump_req) begin
            nv_state <= dcfd_pkg::NV_DUMP;
          end
        end
        dcfd_pkg::NV_DUMP: begin
          if (nv_cnt == dcfd_pkg::NV_WRITE_LAST) begin
            nv_state <= dcfd_pkg::NV_IDLE;
          end else begin
            nv_cnt <= nv_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Nonvolatile rows; unused bits stay zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_row[0] <= '0;
      nv_row[1] <= '0;
    end else if (nv_state == dcfd_pkg::NV_DUMP
                 && nv_cnt == dcfd_pkg::NV_WRITE_LAST) begin
      nv_row[0] <= '0;
      nv_row[0][dcfd_pkg::ROW_HI_LSB +: 8] <= status_byte;
      nv_row[1] <= '0;
      nv_row[1][dcfd_pkg::ROW_HI_LSB +: 8] <=
        cfg[dcfd_pkg::IDX_DATA + 4'h1][dcfd_pkg::DATA_HI_LSB +: 8];
      nv_row[1][dcfd_pkg::ROW_LO_LSB +: 8] <=
        cfg[dcfd_pkg::IDX_DATA][dcfd_pkg::DATA_HI_LSB +: 8];
    end
  end

  // Single-row read copies the selected row into the staging halves.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_lo <= '0;
      stage_hi <= '0;
    end else if (read_one_req && nv_state == dcfd_pkg::NV_IDLE) begin
      stage_lo <= nv_row[cfg[dcfd_pkg::IDX_CCONFIG][dcfd_pkg::CC_ROW_SEL]]
                  [0 +: dcfd_pkg::HALF_W];
      stage_hi <= nv_row[cfg[dcfd_pkg::IDX_CCONFIG][dcfd_pkg::CC_ROW_SEL]]
                  [dcfd_pkg::HALF_W +: dcfd_pkg::HALF_W];
    end
  end

endmodule

`default_nettype wire

// [dcfd_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dcfd_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  cmp_pin_out,
  input wire logic [1:0]  cmp_pin_oe,
  input wire logic [1:0]  fb_hiz_off
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Shadow of the channel 0 output word.
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = aw_hs && s_axi_wvalid && s_axi_wready;
  dcfd_pkg::vout_cfg_t cfg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '0;
    end else if (aw_hs && s_axi_awaddr == 8'h00) begin
      cfg <= dcfd_pkg::vout_cfg_t'(s_axi_wdata[4:0]);
    end
  end

  // Address and data taken together; the response comes two edges on.
  sequence s_wr_ok;
    w_hs && s_axi_awaddr < 8'h40;
  endsequence
  sequence s_wr_bad;
    w_hs && s_axi_awaddr >= 8'h40;
  endsequence

  AST_WR_OKAY: assert property (s_wr_ok |=> ##1 s_axi_bvalid
    && s_axi_bresp == dcfd_pkg::RESP_OKAY)
    else $error("mapped write not okay");
  AST_WR_SLVERR: assert property (s_wr_bad |=> ##1 s_axi_bvalid
    && s_axi_bresp == dcfd_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_B_DROP: assert property (s_axi_bvalid |=> !s_axi_bvalid)
    else $error("bvalid held");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held");
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
  AST_FB_HIZ: assert property (
    $stable(cfg)[*3] |-> fb_hiz_off[0] == cfg.fb_hiz_disable)
    else $error("feedback impedance wrong");
  AST_PIN_OFF: assert property (
    !(cfg.cmp_enable && cfg.cmp_pin_out_enable)[*4] |-> !cmp_pin_oe[0])
    else $error("pin driven while off");
  AST_PUSH_PULL: assert property (
    (cfg[2:0] == 3'h3)[*4] |-> cmp_pin_oe[0])
    else $error("push-pull pin not driven");
  AST_OPEN_DRAIN: assert property (
    (cfg[2:0] == 3'h7)[*4] |-> !cmp_pin_out[0])
    else $error("open-drain pin drives high");
endmodule

bind dac_comparator_fault_dump_ctrl dcfd_asserts u_asserts (.*);
`default_nettype wire

// [dcfd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dcfd_host (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready,
  output var  logic        hung
);
  // Idle bus; both answer channels are always accepted.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_wstrb, hung} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end

  // One write; address and data are released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    hung <= hung | !s_axi_bvalid;
  endtask

  // One read; the address is released once taken.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    hung <= hung | !s_axi_rvalid;
  endtask

  // Both halves of the staged row, fetched through the staging address.
  task automatic fetch(output logic [31:0] row);
    logic [1:0]  r;
    logic [31:0] lo, hi;
    wr(8'h38, {16'h0, dcfd_pkg::STG_LO_ADDR}, r);
    rd(8'h3c, lo, r);
    wr(8'h38, {16'h0, dcfd_pkg::STG_HI_ADDR}, r);
    rd(8'h3c, hi, r);
    row = {hi[15:0], lo[15:0]};
  endtask
endmodule
`default_nettype wire

// [dac_comparator_fault_dump_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dac_comparator_fault_dump_ctrl_tb_top;
  logic             aclk, aresetn, gpio_in, gpio_out, gpio_oe, hung;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [1:0][11:0] feedback_input;
  logic [1:0]       cmp_pin_out, cmp_pin_oe, fb_hiz_off;
  int               failures, check_count;

  dac_comparator_fault_dump_ctrl u_dut (.*);
  dcfd_host u_host (.*);

  // Free-running clock; a stuck bus transfer ends the run.
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (hung === 1'b1) begin
      failures++;
      end_of_test();
    end
  end

  // Comparison, register access and input helpers.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] idx, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr({2'h0, idx, 2'h0}, d, r);
    check({30'h0, r}, {30'h0, dcfd_pkg::RESP_OKAY});
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [31:0] m, exp);
    logic [1:0]  r;
    logic [31:0] d;
    u_host.rd({2'h0, idx, 2'h0}, d, r);
    check(d & m, exp);
  endtask
  task automatic fb(input logic [11:0] v);
    feedback_input[0] <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic st(input logic [31:0] m, exp);
    rchk(dcfd_pkg::IDX_STATUS, m, exp);
  endtask
  task automatic fs(input logic [11:0] v, input logic [31:0] m, exp);
    fb(v);
    st(m, exp);
  endtask
  task automatic cs(input logic [31:0] m, exp);
    wreg(dcfd_pkg::IDX_CHTRIG, 32'h1);
    st(m, exp);
  endtask

  // Reset values, and refusal of an unmapped word.
  task automatic t_reset;
    logic [1:0]  r;
    logic [31:0] d;
    rchk(dcfd_pkg::IDX_VOUT, 32'hffff_ffff, 32'h0);
    check({30'h0, fb_hiz_off}, 32'h0);
    u_host.rd(8'h40, d, r);
    check({30'h0, r}, {30'h0, dcfd_pkg::RESP_SLVERR});
    u_host.wr(8'h44, 32'hffff_ffff, r);
    check({30'h0, r}, {30'h0, dcfd_pkg::RESP_SLVERR});
  endtask

  // Every output setting in normal mode, at the comparator level set by bit 4.
  task automatic t_pins;
    logic [4:0] c;
    logic       v;
    wreg(dcfd_pkg::IDX_DATA, 32'h0000_1000);
    for (int k = 0; k < 32; k++) begin
      c = 5'(k);
      v = c[4] ^ c[3];
      fb(c[4] ? 12'h800 : 12'h000);
      wreg(dcfd_pkg::IDX_VOUT, {27'h0, c});
      repeat (4) @(posedge aclk);
      check({31'h0, cmp_pin_oe[0]}, {31'h0, &c[1:0] & !(c[2] & v)});
      check({31'h0, fb_hiz_off[0]}, {31'h0, c[4]});
      if (c[1:0] == 2'h3) begin
        check({31'h0, cmp_pin_out[0]}, {31'h0, v & !c[2]});
      end
    end
  endtask

  // Hysteresis, latching, flag reset and the other mode codes.
  task automatic t_hyst;
    wreg(dcfd_pkg::IDX_VOUT, 32'h3);
    wreg(dcfd_pkg::IDX_MHIGH, 32'h800);
    wreg(dcfd_pkg::IDX_MLOW, 32'h400);
    wreg(dcfd_pkg::IDX_MODE, 32'h1);
    fs(12'h900, 32'h4, 32'h4);
    fs(12'h600, 32'h4, 32'h4);
    fs(12'h200, 32'h4, 32'h0);
    fs(12'h600, 32'h4, 32'h0);
    wreg(dcfd_pkg::IDX_MHIGH, 32'hfff);
    cs(32'h4, 32'h4);
    fs(12'h200, 32'h4, 32'h0);
    cs(32'h4, 32'h0);
    fs(12'h600, 32'h4, 32'h0);
    cs(32'h4, 32'h4);
    wreg(dcfd_pkg::IDX_MODE, 32'h3);
    st(32'h4, 32'h0);
    wreg(dcfd_pkg::IDX_MODE, 32'h0);
    st(32'h4, 32'h4);
  endtask

  // Window status, live then latched, its clear and its alarm pin.
  task automatic t_win;
    wreg(dcfd_pkg::IDX_MODE, 32'h2);
    wreg(dcfd_pkg::IDX_MHIGH, 32'h800);
    fs(12'h900, 32'h1, 32'h1);
    check({31'h0, cmp_pin_out[0]}, 32'h0);
    wreg(dcfd_pkg::IDX_VOUT, 32'h1);
    fs(12'h600, 32'h1, 32'h0);
    wreg(dcfd_pkg::IDX_CCONFIG, 32'h1);
    fb(12'h200);
    fs(12'h600, 32'h1, 32'h1);
    cs(32'h1, 32'h0);
    fb(12'h900);
    cs(32'h1, 32'h1);
    wreg(dcfd_pkg::IDX_CCONFIG, 32'h5);
    fb(12'h900);
    check({28'h0, cmp_pin_oe, gpio_out, gpio_oe}, 32'h1);
  endtask

  // Dump from register or pin, then read both rows back.
  task automatic t_dump(input logic pin, input logic [15:0] d0, d1);
    logic [31:0] row;
    logic [1:0]  r;
    int          n;
    wreg(dcfd_pkg::IDX_DATA, {16'h0, d0});
    wreg(dcfd_pkg::IDX_DATA + 4'h1, {16'h0, d1});
    if (pin) begin
      gpio_in <= 1'b0;
      repeat (8) @(posedge aclk);
      gpio_in <= 1'b1;
    end else begin
      wreg(dcfd_pkg::IDX_CTRIG, 32'h1);
    end
    st(32'h10, 32'h10);
    n = 0;
    do begin
      u_host.rd(8'h34, row, r);
      n++;
    end while (row[4] !== 1'b0 && n < 400);
    check({31'h0, row[4]}, 32'h0);
    wreg(dcfd_pkg::IDX_CCONFIG, 32'h1);
    wreg(dcfd_pkg::IDX_CTRIG, 32'h2);
    rchk(dcfd_pkg::IDX_CTRIG, 32'hffff_ffff, 32'h0);
    u_host.fetch(row);
    check(row & 32'h0f00_0000, 32'h0100_0000);
    wreg(dcfd_pkg::IDX_CCONFIG, 32'h3);
    wreg(dcfd_pkg::IDX_CTRIG, 32'h2);
    u_host.fetch(row);
    check(row & 32'hff00_00ff, {d1[15:8], 16'h0, d0[15:8]});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    aresetn = 1'b0;
    gpio_in = 1'b1;
    feedback_input = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_pins();
    t_hyst();
    t_win();
    t_dump(1'b0, 16'h12f0, 16'h34f0);
    t_dump(1'b1, 16'hab00, 16'hcd00);
    end_of_test();
  end
endmodule
`default_nettype wire
